// *** common/ddr3b_pkg.sv ***
// constants shared by the bank, read-path and link-side logic
// assumes one x8 part: eight banks, fifteen row bits, ten column bits
package ddr3b_pkg;
  // command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  // address bit positions
  localparam int AUTO_PRE_BIT    = 10;   // a10: auto precharge / all banks
  localparam int BURST_CHOP_BIT  = 12;   // burst_chop_select
  localparam int NIBBLE_BIT      = 2;    // read address a2: nibble order
  localparam int COL_W           = 10;   // column a0..a9
  localparam int ROW_W           = 15;   // row a0..a14
  localparam int BANK_W          = 3;
  localparam int NBANK           = 8;
  // mode_register_three layout
  localparam logic [2:0] MR3_BANK      = 3'h3;
  localparam int         MR3_MPR_BIT   = 2;
  localparam logic [1:0] LOC_PATTERN   = 2'h0;
  localparam logic       MR3_MPR_RESET = 1'b0;
  localparam logic [1:0] MR3_LOC_RESET = 2'h0;
  // calibration pattern, burst position 0 in bit 0
  localparam logic [7:0] CAL_PATTERN   = 8'haa;
  // beats per burst length
  localparam int BEATS_FULL = 8;
  localparam int BEATS_CHOP = 4;
  // column_to_column_delay in clocks for both burst lengths
  localparam logic [2:0] CCD_CYCLES = 3'h4;
  // link-side sequencer states
  typedef enum logic [1:0] {
    DDR3B_IDLE  = 2'b00,
    DDR3B_PRE   = 2'b01,
    DDR3B_BURST = 2'b10,
    DDR3B_POST  = 2'b11
  } ddr3b_link_e;
endpackage : ddr3b_pkg

// *** rtl/ddr3b_rd_link.sv ***
// link-clock read sequencer: drives read beats and strobe enable
// assumes post_data/post_len8 are held stable from post_toggle until ack_toggle
`timescale 1ns/10ps
module ddr3b_rd_link
  import ddr3b_pkg::*;
(
  // link clock and reset
  input  wire logic        link_clk,
  input  wire logic        resetn,
  // burst handed over from the command clock
  input  wire logic        post_toggle,
  input  wire logic [63:0] post_data,
  input  wire logic        post_len8,
  output logic             ack_toggle,
  // read pins, two beats per link clock
  output logic [7:0]       dq_rise,
  output logic [7:0]       dq_fall,
  output logic             dq_oe,
  output logic             dqs_oe
);
  logic        tog_s1;        // first sync stage, read only by tog_s2
  logic        tog_s2;
  logic        tog_seen;      // last toggle value acted on
  logic [63:0] beats;         // captured burst
  logic [1:0]  pair;          // beat pair index
  logic [1:0]  last_pair;     // final pair of this burst
  ddr3b_link_e state;

  // two-flop sync of the request toggle
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
    end else begin
      tog_s1 <= post_toggle;
      tog_s2 <= tog_s1;
    end
  end

  // sequencer: preamble, gapless pairs, postamble
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= DDR3B_IDLE;
      tog_seen   <= 1'b0;
      ack_toggle <= 1'b0;
      beats      <= '0;
      pair       <= 2'h0;
      last_pair  <= 2'h0;
    end else begin
      case (state)
        DDR3B_IDLE: begin
          if (tog_s2 != tog_seen) begin    // new burst waiting
            tog_seen  <= tog_s2;
            beats     <= post_data;
            last_pair <= post_len8 ? 2'h3 : 2'h1; // R15
            pair      <= 2'h0;
            state     <= DDR3B_PRE;
          end
        end
        DDR3B_PRE: begin
          ack_toggle <= ~ack_toggle;       // data captured, slot may refill
          state      <= DDR3B_BURST;
        end
        DDR3B_BURST: begin
          pair <= pair + 2'h1;
          if (pair == last_pair) begin     // R23
            state <= DDR3B_POST;
          end
        end
        DDR3B_POST: begin
          state <= DDR3B_IDLE;
        end
        default: begin
          state <= DDR3B_IDLE;
        end
      endcase
    end
  end

  // pin registers; strobe enable spans preamble to postamble
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      dq_rise <= 8'h00;
      dq_fall <= 8'h00;
      dq_oe   <= 1'b0;
      dqs_oe  <= 1'b0;
    end else begin
      dqs_oe <= (state != DDR3B_IDLE);
      dq_oe  <= (state == DDR3B_BURST);
      if (state == DDR3B_BURST) begin      // R23
        dq_rise <= beats[{pair, 1'b0, 3'h0} +: 8];
        dq_fall <= beats[{pair, 1'b1, 3'h0} +: 8];
      end else begin
        dq_rise <= 8'h00;
        dq_fall <= 8'h00;
      end
    end
  end
endmodule : ddr3b_rd_link

// *** rtl/ddr3b_core.sv ***
// command decode, bank row state, calibration register and read launch
// assumes command pins are sampled on mclk; array returns data with its request
`timescale 1ns/10ps
// Notes on behaviour
// R1: mode three, enable 1, select 00 serves pattern
// R2: full read at 000 gives 0,1,0,1...
// R3: chopped reads 000/100 give nibble 0-3/4-7
// R4: reserved selects: order kept, data meaningless
// R5: position 0 is lsb, position 7 msb
// R6: activate decodes bank inputs and row address
// R7: row stays open until its precharge
// R8: controller precharges before reopening another row
// R9: precharge closes one bank or all banks
// R10: controller waits recovery before next activate
// R11: other-bank access during auto precharge allowed
// R12: precharged bank idle, needs activate first
// R13: precharge to idle bank is harmless
// R14: recovery timed from the latest precharge
// R15: a12 low chops to four, high eight
// R16: a12 never part of column address
// R17: read output only while delay loop locked
// R18: enable 0 routes reads/writes to array
// R19: x8 pattern bit copied on all lines
// R20: controller holds a1:a0 at 00 for pattern
// R21: controller locks loop first, normal latencies
// R22: first beat after additive plus cas latency
// R23: beats back to back, two per clock
module ddr3b_core
  import ddr3b_pkg::*;
#(
  parameter int          PRE_RECOVERY_CYCLES = 8,   // precharge_recovery_time
  parameter int          LAT_W               = 5
) (
  // command clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // command bus
  input  wire logic               cs_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire logic [BANK_W-1:0]  bank_select_inputs,
  input  wire logic [ROW_W-1:0]   addr,
  // latency settings and loop status
  input  wire logic [3:0]         additive_latency,
  input  wire logic [3:0]         cas_latency,
  input  wire logic               dll_locked,
  // array side
  output logic                    array_rd_req,
  output logic                    array_wr_req,
  output logic [BANK_W-1:0]       array_bank,
  output logic [ROW_W-1:0]        array_row,
  output logic [COL_W-1:0]        array_col,
  input  wire logic [63:0]        array_rdata,
  // status
  output logic [NBANK-1:0]        bank_open,
  output logic [NBANK-1:0]        bank_precharging,
  output logic                    mpr_mode,
  output logic                    access_error,
  output logic                    read_overrun,
  // read link
  input  wire logic               link_clk,
  output logic [7:0]              dq_rise,
  output logic [7:0]              dq_fall,
  output logic                    dq_oe,
  output logic                    dqs_oe
);
  localparam logic [LAT_W-1:0] PRE_CNT = LAT_W'(PRE_RECOVERY_CYCLES);

  logic                  dll_s1;          // first sync stage only
  logic                  dll_ok;
  logic [1:0]            mpr_loc;         // location select
  logic [ROW_W-1:0]      open_row [NBANK];
  logic [LAT_W-1:0]      pre_cnt  [NBANK];
  logic [LAT_W-1:0]      lat_cnt;         // read_latency countdown
  logic                  lat_run;
  logic                  pend_len8;
  logic                  pend_hi;
  logic                  pend_mpr;
  logic                  post_toggle;
  logic                  post_busy;
  logic [63:0]           post_data;
  logic                  post_len8;
  logic                  ack_toggle;      // from link domain
  logic                  ack_s1;
  logic                  ack_s2;
  logic                  ack_seen;
  logic [63:0]           next_beats;
  logic [3:0]            cmd;
  logic                  is_act;
  logic                  is_pre;
  logic                  is_rd;
  logic                  is_wr;
  logic                  is_mrs;
  logic                  bank_ready;
  logic                  rd_ok;
  logic                  rd_take;
  logic [LAT_W-1:0]      rl;

  // command decode from the four control pins
  assign cmd    = {cs_n, ras_n, cas_n, we_n};
  assign is_act = (cmd == CMD_ACT);
  assign is_pre = (cmd == CMD_PRE);
  assign is_rd  = (cmd == CMD_READ);
  assign is_wr  = (cmd == CMD_WRITE);
  assign is_mrs = (cmd == CMD_MRS);
  assign rl     = LAT_W'(additive_latency) + LAT_W'(cas_latency); // R22
  // bank address is ignored for pattern reads
  assign bank_ready = bank_open[bank_select_inputs];
  assign rd_ok   = dll_ok && (mpr_mode || bank_ready); // R17 R12 R20
  // one read in flight; a read landing during the latency countdown is flagged
  assign rd_take = is_rd && rd_ok && !lat_run;

  // loop status comes from another domain: two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dll_s1 <= 1'b0;
      dll_ok <= 1'b0;
    end else begin
      dll_s1 <= dll_locked;
      dll_ok <= dll_s1;
    end
  end

  // mode_register_three: pattern enable and location select
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mpr_mode <= MR3_MPR_RESET;
      mpr_loc  <= MR3_LOC_RESET;
    end else if (is_mrs && bank_select_inputs == MR3_BANK) begin
      mpr_mode <= addr[MR3_MPR_BIT];         // R1 R18
      mpr_loc  <= addr[1:0];
    end
  end

  // per-bank row state and recovery timer
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic hit;      // command addresses this bank
      logic pre_hit;  // precharge or auto precharge lands here
      assign hit     = (bank_select_inputs == BANK_W'(b));
      // auto precharge only closes a bank that held the read or write
      assign pre_hit = (is_pre && (hit || addr[AUTO_PRE_BIT])) ||          // R9
                       ((rd_take || (is_wr && bank_ready)) && !mpr_mode &&
                        hit && addr[AUTO_PRE_BIT]);                         // R11
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          bank_open[b]        <= 1'b0;
          bank_precharging[b] <= 1'b0;
          open_row[b]         <= '0;
          pre_cnt[b]          <= '0;
        end else if (pre_hit) begin
          // idle or already closing banks simply restart the timer
          bank_open[b]        <= 1'b0;             // R12 R13
          bank_precharging[b] <= 1'b1;
          pre_cnt[b]          <= PRE_CNT;          // R14
        end else begin
          if (pre_cnt[b] != '0) begin
            pre_cnt[b] <= pre_cnt[b] - LAT_W'(1);
          end
          if (pre_cnt[b] <= LAT_W'(1)) begin
            bank_precharging[b] <= 1'b0;
          end
          // activation only lands on an idle, recovered bank
          if (is_act && hit && !bank_open[b] && pre_cnt[b] == '0) begin
            bank_open[b] <= 1'b1;                  // R6 R7
            open_row[b]  <= addr;                  // R6
          end
        end
      end
    end
  endgenerate

  // error pulse: activate to a busy bank, access to an idle one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      access_error <= 1'b0;
    end else begin
      access_error <= (is_act && (bank_ready ||
                       pre_cnt[bank_select_inputs] != '0)) ||               // R8 R10
                      (is_rd && !(mpr_mode || bank_ready)) ||
                      (is_wr && !bank_ready);                               // R12
    end
  end

  // array request: column excludes a12 and a10
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      array_rd_req <= 1'b0;
      array_wr_req <= 1'b0;
      array_bank   <= '0;
      array_row    <= '0;
      array_col    <= '0;
    end else begin
      array_rd_req <= rd_take && !mpr_mode;        // R18
      array_wr_req <= is_wr && bank_ready;         // R18
      if ((is_rd || is_wr) && bank_ready) begin
        array_bank <= bank_select_inputs;
        array_row  <= open_row[bank_select_inputs];
        array_col  <= addr[COL_W-1:0];             // R16
      end
    end
  end

  // read latency countdown and burst shape capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lat_run      <= 1'b0;
      lat_cnt      <= '0;
      pend_len8    <= 1'b1;
      pend_hi      <= 1'b0;
      pend_mpr     <= 1'b0;
      read_overrun <= 1'b0;
    end else begin
      read_overrun <= is_rd && rd_ok && lat_run;
      if (rd_take) begin
        lat_run   <= 1'b1;
        lat_cnt   <= rl;                                  // R22
        pend_len8 <= addr[BURST_CHOP_BIT];                // R15
        pend_hi   <= !addr[BURST_CHOP_BIT] && addr[NIBBLE_BIT]; // R3
        pend_mpr  <= mpr_mode;
      end else if (lat_run) begin
        lat_cnt <= lat_cnt - LAT_W'(1);
        if (lat_cnt <= LAT_W'(1)) begin
          lat_run <= 1'b0;
        end
      end
    end
  end

  // beat assembly in burst order
  genvar i;
  generate
    for (i = 0; i < BEATS_FULL; i++) begin : g_beat
      logic [2:0] pos;   // burst position served in beat i
      assign pos = pend_hi ? 3'(i + BEATS_CHOP) : 3'(i);  // R3
      // pattern bit copied on all eight lines
      assign next_beats[i*8 +: 8] =
        !pend_mpr ? array_rdata[{pos, 3'h0} +: 8] :       // R18
        (mpr_loc == LOC_PATTERN) ? {8{CAL_PATTERN[pos]}} : // R1 R2 R5 R19
        8'h00;                                             // R4
    end
  endgenerate

  // ack toggle from link domain: two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_toggle;
      ack_s2 <= ack_s1;
    end
  end

  // post slot: held stable until the link acknowledges
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      post_toggle <= 1'b0;
      post_busy   <= 1'b0;
      post_data   <= '0;
      post_len8   <= 1'b1;
      ack_seen    <= 1'b0;
    end else begin
      if (ack_s2 != ack_seen) begin
        ack_seen  <= ack_s2;
        post_busy <= 1'b0;
      end
      // launch only into a free slot; a burst finding the slot busy is dropped unflagged
      if (lat_run && lat_cnt <= LAT_W'(1) && !post_busy) begin
        post_data   <= next_beats;
        post_len8   <= pend_len8;                  // R15
        post_toggle <= ~post_toggle;
        post_busy   <= 1'b1;
      end
    end
  end

  // link-clock side drives the pins
  ddr3b_rd_link u_link (
    .link_clk    (link_clk),
    .resetn      (resetn),
    .post_toggle (post_toggle),
    .post_data   (post_data),
    .post_len8   (post_len8),
    .ack_toggle  (ack_toggle),
    .dq_rise     (dq_rise),
    .dq_fall     (dq_fall),
    .dq_oe       (dq_oe),
    .dqs_oe      (dqs_oe)
  );
endmodule : ddr3b_core

// *** test/ddr3b_core_props.sv ***
// checker: bank row state, mode three, read launch and strobe framing
// assumes it is bound to ddr3b_core and sees only its ports
`timescale 1ns/10ps
module ddr3b_core_props
  import ddr3b_pkg::*;
(
  // clocks and reset
  input wire logic              mclk,
  input wire logic              link_clk,
  input wire logic              resetn,
  // command bus
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] bank_select_inputs,
  input wire logic [ROW_W-1:0]  addr,
  // status and read outputs
  input wire logic [NBANK-1:0]  bank_open,
  input wire logic [NBANK-1:0]  bank_precharging,
  input wire logic              mpr_mode,
  input wire logic              access_error,
  input wire logic              array_rd_req,
  input wire logic [BANK_W-1:0] array_bank,
  input wire logic [COL_W-1:0]  array_col,
  input wire logic              dq_oe,
  input wire logic              dqs_oe
);
  // decoded command; deselect never matches a code
  wire logic [3:0]        cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic              rw  = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  wire logic [BANK_W-1:0] ba  = bank_select_inputs;

  act_open_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd == CMD_ACT && !bank_open[ba] && !bank_precharging[ba] |=> bank_open[$past(ba)])
    else $error("activate did not open bank");
  act_busy_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd == CMD_ACT && (bank_open[ba] || bank_precharging[ba]) |=> access_error)
    else $error("activate to busy bank not flagged");
  idle_rw_a: assert property (@(posedge mclk) disable iff (!resetn)
    rw && !bank_open[ba] && !mpr_mode |=> access_error)
    else $error("access to idle bank not flagged");
  pre_one_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd == CMD_PRE && !addr[AUTO_PRE_BIT] |=> !bank_open[$past(ba)] && bank_precharging[$past(ba)])
    else $error("single bank close failed");
  pre_all_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd == CMD_PRE && addr[AUTO_PRE_BIT] |=> bank_open == 8'h00)
    else $error("close of all banks failed");
  row_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd != CMD_PRE && !(rw && addr[AUTO_PRE_BIT]) |=> (bank_open & $past(bank_open)) == $past(bank_open))
    else $error("open row closed without precharge");
  mode_three_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd == CMD_MRS && ba == MR3_BANK |=> mpr_mode == $past(addr[MR3_MPR_BIT]))
    else $error("mode three enable not taken");
  rd_addr_a: assert property (@(posedge mclk) disable iff (!resetn)
    array_rd_req |-> $past(cmd) == CMD_READ && !$past(mpr_mode) && array_bank == $past(ba)
      && array_col == $past(addr[COL_W-1:0]))
    else $error("array read address wrong");
  strobe_a: assert property (@(posedge link_clk) disable iff (!resetn)
    dq_oe |-> dqs_oe)
    else $error("data driven without strobe");
  burst_len_a: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(dq_oe) |=> dq_oe)
    else $error("burst shorter than two pairs");
  strobe_pre_a: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(dq_oe) |-> $past(dqs_oe))
    else $error("data started without strobe preamble");
  strobe_post_a: assert property (@(posedge link_clk) disable iff (!resetn)
    $fell(dq_oe) |-> dqs_oe)
    else $error("strobe dropped without postamble");

  // main scenarios reached
  cover property (@(posedge mclk) cmd == CMD_PRE && addr[AUTO_PRE_BIT]);
  cover property (@(posedge mclk) access_error);
  cover property (@(posedge mclk) mpr_mode && cmd == CMD_READ);
  cover property (@(posedge link_clk) $rose(dq_oe));
endmodule : ddr3b_core_props

// *** test/ddr3b_ctrl_model.sv ***
// controller model: drives one command at a time on the command pins
// assumes commands launch just after a rising mclk edge
`timescale 1ns/10ps
module ddr3b_ctrl_model
  import ddr3b_pkg::*;
(
  // clock and loop status
  input wire logic          mclk,
  input wire logic          dll_locked,
  // command bus
  output logic              cs_n,
  output logic              ras_n,
  output logic              cas_n,
  output logic              we_n,
  output logic [BANK_W-1:0] bank,
  output logic [ROW_W-1:0]  addr
);
  // deselected from time zero
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank = 3'h0;
    addr = 15'h0000;
  end
  // one command cycle, then deselect with the address inverted
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
    @(posedge mclk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    bank = b;
    addr = a;
    @(posedge mclk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank = ~b;
    addr = ~a;  // stale address must not look valid
  endtask : issue
  // read: only with a locked loop, low column bits forced to 00
  task automatic rd(input logic [2:0] b, input logic [14:0] a);
    wait (dll_locked === 1'b1);
    issue(CMD_READ, b, {a[14:2], 2'h0});
  endtask : rd
endmodule : ddr3b_ctrl_model

// *** test/ddr3b_core_bench.sv ***
// testbench: bank rows, array reads and calibration pattern reads
// assumes the controller model drives commands; beats are queued per link clock
`timescale 1ns/10ps
module ddr3b_core_bench
  import ddr3b_pkg::*;
;
  // clocks, reset and static settings
  logic        mclk;
  logic        link_clk;
  logic        resetn;
  logic        dll_locked;
  logic [3:0]  additive_latency = 4'h1;
  logic [3:0]  cas_latency      = 4'h5;
  logic [63:0] array_rdata      = 64'h0123_4567_89ab_cdef;
  // command pins and design outputs
  logic        cs_n, ras_n, cas_n, we_n;
  logic [2:0]  bank_select_inputs, array_bank;
  logic [14:0] addr, array_row;
  logic [9:0]  array_col;
  logic        array_rd_req, array_wr_req, access_error, read_overrun, mpr_mode, dq_oe, dqs_oe;
  logic [7:0]  bank_open, bank_precharging, dq_rise, dq_fall;
  // bookkeeping
  int          error_cnt;
  int          check_count;
  logic [7:0]  rx_q[$];

  // short recovery keeps the waits small
  ddr3b_core #(.PRE_RECOVERY_CYCLES(6)) i_ddr3b_core (
    .mclk, .resetn, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_inputs, .addr,
    .additive_latency, .cas_latency, .dll_locked, .array_rd_req, .array_wr_req,
    .array_bank, .array_row, .array_col, .array_rdata, .bank_open, .bank_precharging,
    .mpr_mode, .access_error, .read_overrun, .link_clk, .dq_rise, .dq_fall, .dq_oe, .dqs_oe);
  ddr3b_ctrl_model i_ddr3b_ctrl_model (
    .mclk, .dll_locked, .cs_n, .ras_n, .cas_n, .we_n, .bank(bank_select_inputs), .addr);

  // clocks, unrelated in phase
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  // two beats per link clock while data is driven; taken mid-cycle, where the pins have settled
  always @(negedge link_clk) begin
    if (dq_oe === 1'b1) begin
      rx_q.push_back(dq_rise);
      rx_q.push_back(dq_fall);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
    i_ddr3b_ctrl_model.issue(c, b, a);
  endtask : cmd
  // read, then compare the beats in burst order
  task automatic chk_rd(input logic [2:0] b, input logic [14:0] a, input logic [63:0] exp, input int n);
    rx_q.delete();
    i_ddr3b_ctrl_model.rd(b, a);
    tick(60);
    cmp("beat count", 64'(n), 64'(rx_q.size()));
    for (int k = 0; k < n && k < rx_q.size(); k++) begin
      cmp("beat", 64'(exp[8*k +: 8]), 64'(rx_q[k]));
    end
  endtask : chk_rd

  task automatic t_rows;
    cmd(CMD_ACT, 3'h5, 15'h1234);
    cmp("open", 64'(8'h20), 64'(bank_open));
    cmd(CMD_ACT, 3'h5, 15'h0042);
    cmp("reopen error", 64'(1'b1), 64'(access_error));
    cmd(CMD_PRE, 3'h5, 15'h0000);
    cmp("closed", 64'(8'h00), 64'(bank_open));
    cmd(CMD_PRE, 3'h5, 15'h0000);
    cmp("repeat close error", 64'(1'b0), 64'(access_error));
    cmd(CMD_ACT, 3'h5, 15'h1234);
    cmp("early open error", 64'(1'b1), 64'(access_error));
    tick(3);
    cmp("recovering", 64'(8'h20), 64'(bank_precharging));
    tick(4);
    cmp("recovered", 64'(8'h00), 64'(bank_precharging));
    cmd(CMD_ACT, 3'h5, 15'h1234);
    cmp("open again", 64'(8'h20), 64'(bank_open));
  endtask : t_rows

  task automatic t_array;
    cmd(CMD_READ, 3'h2, 15'h1000);
    cmp("idle read error", 64'(1'b1), 64'(access_error));
    dll_locked = 1'b0;
    tick(4);
    rx_q.delete();
    cmd(CMD_READ, 3'h5, 15'h1000);
    tick(60);
    cmp("unlocked beats", 64'h0, 64'(rx_q.size()));
    dll_locked = 1'b1;
    tick(4);
    chk_rd(3'h5, 15'h12a8, array_rdata, 8);
    cmp("column", 64'(10'h2a8), 64'(array_col));
    cmp("row", 64'(15'h1234), 64'(array_row));
    chk_rd(3'h5, 15'h00a8, array_rdata, 4);
    chk_rd(3'h5, 15'h00ac, array_rdata >> 32, 4);
    // a second read inside the latency window is dropped and flagged
    rx_q.delete();
    cmd(CMD_READ, 3'h5, 15'h1000);
    cmd(CMD_READ, 3'h5, 15'h1000);
    cmp("overrun", 64'(1'b1), 64'(read_overrun));
    tick(60);
    cmp("kept beats", 64'(8), 64'(rx_q.size()));
    cmd(CMD_WRITE, 3'h5, 15'h0000);
    cmp("array write", 64'(1'b1), 64'(array_wr_req));
    cmd(CMD_ACT, 3'h2, 15'h0077);
    chk_rd(3'h2, 15'h1400, array_rdata, 8);
    cmp("auto closed", 64'(8'h20), 64'(bank_open));
    cmd(CMD_PRE, 3'h0, 15'h0400);
    cmp("all closed", 64'(8'h00), 64'(bank_open));
  endtask : t_array

  task automatic t_pattern;
    cmd(CMD_MRS, MR3_BANK, 15'h0004);
    cmp("pattern mode", 64'(1'b1), 64'(mpr_mode));
    chk_rd(3'h7, 15'h1000, 64'hff00_ff00_ff00_ff00, 8);
    chk_rd(3'h1, 15'h0000, 64'hff00_ff00_ff00_ff00, 4);
    chk_rd(3'h1, 15'h0004, 64'hff00_ff00_ff00_ff00, 4);
    // reserved select: full burst still framed, content reads zero here
    cmd(CMD_MRS, MR3_BANK, 15'h0005);
    chk_rd(3'h1, 15'h1000, 64'h0000_0000_0000_0000, 8);
    cmd(CMD_MRS, MR3_BANK, 15'h0000);
    cmp("pattern mode off", 64'(1'b0), 64'(mpr_mode));
    cmd(CMD_READ, 3'h7, 15'h1000);
    cmp("array idle error", 64'(1'b1), 64'(access_error));
  endtask : t_pattern

  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin : main
    resetn     = 1'b0;
    dll_locked = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    resetn     = 1'b1;
    dll_locked = 1'b1;
    tick(4);
    t_rows();
    t_array();
    t_pattern();
    end_of_test();
  end
  // watchdog well beyond the expected run
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
endmodule : ddr3b_core_bench

bind ddr3b_core ddr3b_core_props i_ddr3b_core_props (
  .mclk, .link_clk, .resetn, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_inputs, .addr,
  .bank_open, .bank_precharging, .mpr_mode, .access_error, .array_rd_req, .array_bank,
  .array_col, .dq_oe, .dqs_oe);
